/* File: design/ddr_pre_pkg.sv */
// Constants, field positions and types shared by the preamble logic
package ddr_pre_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_PS = 40000;
  localparam int T_SDO_NS      = 400;
  localparam int SDO_CYC       = (T_SDO_NS * 1000 + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int OCC_W         = 32;

  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_LAT  = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_PAT  = 4'hC;

  // Control register fields
  localparam int CTRL_X16      = 0;
  localparam int CTRL_CRC      = 1;
  localparam int CTRL_MPR      = 2;
  localparam int CTRL_PAGE_LSB = 3;

  // Status register fields
  localparam int STAT_VIOL = 4;

  // Reset values
  localparam logic [4:0]  CL_RST  = 5'h0B;
  localparam logic [4:0]  CWL_RST = 5'h0C;
  localparam logic [31:0] PAT_RST = 32'h0000_0000;

  // Mode register 4 fields and select code
  localparam logic [2:0] MR_SEL_MR4   = 3'h4;
  localparam int         MR4_WPRE_BIT = 12;
  localparam int         MR4_RPRE_BIT = 11;
  localparam int         MR4_RTRN_BIT = 10;

  // Burst length in clocks and forbidden column spacings
  localparam logic [3:0] BL8_MASK = 4'hF;
  localparam logic [3:0] BC4_MASK = 4'h3;
  localparam logic [3:0] GAP_5    = 4'h5;
  localparam logic [3:0] GAP_6    = 4'h6;
  localparam logic [3:0] GAP_MAX  = 4'hF;

  // Command codes on the command pins
  typedef enum logic [1:0] {
    CMD_MRS = 2'h0,
    CMD_ACT = 2'h1,
    CMD_RD  = 2'h2,
    CMD_WR  = 2'h3
  } cmd_e;

  // Read preamble training states
  typedef enum logic [2:0] {
    TRN_OFF  = 3'b001,
    TRN_WAIT = 3'b010,
    TRN_HOLD = 3'b100
  } trn_e;

endpackage

/* File: design/ddr_preamble_ctl.sv */
// Preamble modes, read preamble training and bank group tracking
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module ddr_preamble_ctl
  import ddr_pre_pkg::*;
(
  input  wire logic        CORE_CLK,        // Core clock, 25 MHz
  input  wire logic        RST_N,           // Reset, active low
  input  wire logic [3:0]  AVS_ADDRESS,     // Register byte address
  input  wire logic        AVS_READ,        // Read request
  input  wire logic        AVS_WRITE,       // Write request
  input  wire logic [31:0] AVS_WRITEDATA,   // Write data
  input  wire logic [3:0]  AVS_BYTEENABLE,  // Write byte lanes
  output logic      [31:0] AVS_READDATA,    // Read data
  output logic             AVS_WAITREQUEST, // Stall
  input  wire logic        CMD_VALID,       // Command strobe
  input  wire logic [1:0]  CMD_TYPE,        // Command code
  input  wire logic [1:0]  CMD_BG,          // Bank group
  input  wire logic [1:0]  CMD_BA,          // Bank
  input  wire logic [2:0]  CMD_MR,          // Mode register select
  input  wire logic [12:0] CMD_OP,          // Mode register operand
  input  wire logic        CMD_BC4,         // Burst chop
  output logic      [1:0]  RD_DQS_T_H,      // Read strobe true
  output logic      [1:0]  RD_DQS_C_H,      // Read strobe complement
  output logic      [1:0]  RD_DQS_OE_H,     // Read strobe enable
  output logic      [1:0]  DQ_H,            // Data level per half
  output logic             DQ_OE,           // Data drive enable
  output logic      [1:0]  WR_DQS_EXP_H,    // Expected write strobe
  output logic      [1:0]  WR_DQS_EN_H,     // Write strobe window
  output logic      [3:0]  ACT_BANK,        // Last activated bank
  output logic      [3:0]  COL_BANK         // Last column bank
);

  typedef struct packed {
    logic             ack;
    logic [31:0]      rdata;
    logic             x16;
    logic             crc;
    logic             mpr;
    logic [1:0]       page;
    logic [4:0]       cl;
    logic [4:0]       cwl;
    logic [31:0]      pats;
    logic             wpre2;
    logic             rpre2;
    trn_e             trn;
    logic [3:0]       sdo;
    logic [OCC_W-1:0] rocc;
    logic [OCC_W-1:0] wocc;
    logic [3:0]       cgap;
    logic             viol;
    logic [3:0]       act_bank;
    logic [3:0]       col_bank;
    logic [7:0]       pat_sel;
  } ctl_s;

  ctl_s        r;
  ctl_s        n;
  logic        rst_q1;
  logic        rst_n;
  logic        wr_acc;
  logic        mrs4;
  logic        rd_go;
  logic        wr_go;
  logic [1:0]  bg;
  logic [31:0] wmask;
  logic [31:0] ctrl_v;
  logic [31:0] lat_v;
  logic [31:0] stat_v;
  logic [31:0] rd_val;
  logic [31:0] merged;
  logic [OCC_W-1:0] bmask;
  logic        is_wait;
  logic        is_hold;

  strobe_if rs ();
  strobe_if ws ();

  // Reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_q1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else
    begin
      rst_q1 <= 1'b1;
      rst_n  <= rst_q1;
    end
  end

  // Decode of bus and command pins
  assign wr_acc  = AVS_WRITE & r.ack;
  assign mrs4    = CMD_VALID && CMD_TYPE == CMD_MRS && CMD_MR == MR_SEL_MR4;
  assign is_wait = r.trn == TRN_WAIT;
  assign is_hold = r.trn == TRN_HOLD;
  assign bg      = r.x16 ? {1'b0, CMD_BG[0]} : CMD_BG;
  assign rd_go   = CMD_VALID && CMD_TYPE == CMD_RD && !is_wait
                   && (!is_hold || r.page == 2'd0);
  assign wr_go   = CMD_VALID && CMD_TYPE == CMD_WR;
  assign bmask   = {{(OCC_W - 4){1'b0}}, CMD_BC4 ? BC4_MASK : BL8_MASK};
  assign wmask   = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
  assign ctrl_v  = {27'h0, r.page, r.mpr, r.crc, r.x16};
  assign lat_v   = {19'h0, r.cwl, 3'h0, r.cl};
  assign stat_v  = {16'h0, r.col_bank, r.act_bank, 3'h0, r.viol,
                    is_hold, is_wait, r.rpre2, r.wpre2};

  // Register read mux, unmapped reads as zero
  always_comb
  begin
    unique case (AVS_ADDRESS)
      REG_CTRL: rd_val = ctrl_v;
      REG_LAT:  rd_val = lat_v;
      REG_STAT: rd_val = stat_v;
      REG_PAT:  rd_val = r.pats;
      default:  rd_val = 32'h0000_0000;
    endcase
  end

  // Next state of the whole block
  always_comb
  begin
    n      = r;
    merged = 32'h0000_0000;
    n.ack  = (AVS_READ | AVS_WRITE) & ~r.ack;
    if (AVS_READ && !r.ack)
      n.rdata = rd_val;
    if (wr_acc && AVS_ADDRESS == REG_CTRL)
    begin
      merged = (ctrl_v & ~wmask) | (AVS_WRITEDATA & wmask);
      n.x16  = merged[CTRL_X16];
      n.crc  = merged[CTRL_CRC];
      n.mpr  = merged[CTRL_MPR];
      n.page = merged[CTRL_PAGE_LSB +: 2];
    end
    if (wr_acc && AVS_ADDRESS == REG_LAT)
    begin
      merged = (lat_v & ~wmask) | (AVS_WRITEDATA & wmask);
      n.cl   = merged[4:0];
      n.cwl  = merged[12:8];
    end
    if (wr_acc && AVS_ADDRESS == REG_PAT)
      n.pats = (r.pats & ~wmask) | (AVS_WRITEDATA & wmask);
    // Sticky spacing error, set beats a same-cycle clear
    if (wr_acc && AVS_ADDRESS == REG_STAT && AVS_BYTEENABLE[0]
        && AVS_WRITEDATA[STAT_VIOL])
      n.viol = 1'b0;
    if ((rd_go && r.rpre2 && r.cgap == GAP_5)
        || (wr_go && r.wpre2 && r.cgap == (r.crc ? GAP_6 : GAP_5)))
      n.viol = 1'b1;
    // Training settle count
    unique case (r.trn)
      TRN_OFF:  n.sdo = 4'h0;
      TRN_WAIT:
      begin
        n.sdo = r.sdo + 4'h1;
        if (r.sdo == 4'(SDO_CYC - 1))
          n.trn = TRN_HOLD;
      end
      TRN_HOLD: n.sdo = 4'h0;
    endcase
    // Mode register 4 write
    if (mrs4)
    begin
      n.wpre2 = CMD_OP[MR4_WPRE_BIT];
      n.rpre2 = CMD_OP[MR4_RPRE_BIT];
      if (!CMD_OP[MR4_RTRN_BIT])
        n.trn = TRN_OFF;
      else if (r.mpr && r.trn == TRN_OFF)
      begin
        n.trn = TRN_WAIT;
        n.sdo = 4'h0;
      end
    end
    // Bank tracking
    if (CMD_VALID && CMD_TYPE == CMD_ACT)
      n.act_bank = {bg, CMD_BA};
    if (rd_go || wr_go)
    begin
      n.col_bank = {bg, CMD_BA};
      n.cgap     = 4'h1;
    end
    else if (r.cgap != GAP_MAX)
      n.cgap = r.cgap + 4'h1;
    if (rd_go)
      n.pat_sel = r.pats[{CMD_OP[1:0], 3'b000} +: 8];
    // Burst occupancy schedules
    // Bit k of a fresh schedule is the clock after edge k from the command
    n.rocc = (r.rocc >> 1) | (rd_go ? bmask << r.cl : '0);
    n.wocc = (r.wocc >> 1) | (wr_go ? bmask << r.cwl : '0);
  end

  // State register
  always_ff @(posedge CORE_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r       <= '0;
      r.cl    <= CL_RST;
      r.cwl   <= CWL_RST;
      r.pats  <= PAT_RST;
      r.trn   <= TRN_OFF;
      r.cgap  <= GAP_MAX;
    end
    else
      r <= n;
  end

  // Sequencer hookup
  assign rs.occ     = r.rocc[3:0];
  assign rs.two_clk = r.rpre2;
  assign rs.hold    = is_hold;
  assign rs.pat     = r.pat_sel;
  assign ws.occ     = r.wocc[3:0];
  assign ws.two_clk = r.wpre2;
  assign ws.hold    = 1'b0;
  assign ws.pat     = 8'h00;

  strobe_seq u_rd_seq (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .sif   (rs.seq)
  );

  strobe_seq u_wr_seq (
    .clk   (CORE_CLK),
    .rst_n (rst_n),
    .sif   (ws.seq)
  );

  // Outputs
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~r.ack;
  assign AVS_READDATA    = r.rdata;
  assign RD_DQS_T_H      = rs.t_h;
  assign RD_DQS_C_H      = ~rs.t_h;
  assign RD_DQS_OE_H     = rs.oe_h;
  assign DQ_H            = rs.dq_oe ? rs.dq_h : 2'b11;
  // Hold term covers the clock before the sequencer enters its hold shape
  assign DQ_OE           = rs.dq_oe | is_wait | is_hold;
  assign WR_DQS_EXP_H    = ws.t_h;
  assign WR_DQS_EN_H     = ws.oe_h;
  assign ACT_BANK        = r.act_bank;
  assign COL_BANK        = r.col_bank;

  property p_wpre1;
    @(posedge CORE_CLK) disable iff (!rst_n)
      $rose(ws.burst) && !r.wpre2 && !$past(ws.burst, 2)
      |-> $past(ws.pre, 1) && !$past(ws.pre, 2);
  endproperty
  a_wpre1: assert property (p_wpre1)
    else $error("write preamble not one clock");

  property p_wpre2;
    @(posedge CORE_CLK) disable iff (!rst_n)
      $rose(ws.burst) && r.wpre2 && !$past(ws.burst, 2)
      && !$past(ws.burst, 3) |-> $past(ws.pre, 1) && $past(ws.pre, 2);
  endproperty
  a_wpre2: assert property (p_wpre2)
    else $error("write preamble not two clocks");

  property p_rpre1;
    @(posedge CORE_CLK) disable iff (!rst_n)
      $rose(rs.burst) && !r.rpre2 && !is_hold && !$past(rs.burst, 2)
      |-> $past(RD_DQS_OE_H, 1) == 2'b11 && !$past(rs.pre, 2);
  endproperty
  a_rpre1: assert property (p_rpre1)
    else $error("read preamble not one clock");

  property p_rpre2;
    @(posedge CORE_CLK) disable iff (!rst_n)
      $rose(rs.burst) && r.rpre2 && !$past(rs.burst, 2)
      && !$past(rs.burst, 3) |-> $past(rs.pre, 1) && $past(rs.pre, 2);
  endproperty
  a_rpre2: assert property (p_rpre2)
    else $error("read preamble not two clocks");

  property p_indep;
    @(posedge CORE_CLK) disable iff (!rst_n)
      mrs4 |=> r.wpre2 == $past(CMD_OP[MR4_WPRE_BIT])
               && r.rpre2 == $past(CMD_OP[MR4_RPRE_BIT]);
  endproperty
  a_indep: assert property (p_indep)
    else $error("preamble modes not set independently");

  property p_trn_gate;
    @(posedge CORE_CLK) disable iff (!rst_n)
      mrs4 && CMD_OP[MR4_RTRN_BIT] && !r.mpr && r.trn == TRN_OFF
      |=> r.trn == TRN_OFF;
  endproperty
  a_trn_gate: assert property (p_trn_gate)
    else $error("training entered outside pattern access mode");

  property p_settle;
    @(posedge CORE_CLK) disable iff (!rst_n)
      $rose(is_hold) |-> $past(is_wait, 1) && $past(is_wait, 10)
                         && DQ_OE && DQ_H == 2'b11;
  endproperty
  a_settle: assert property (p_settle)
    else $error("training hold before settle time or data not high");

  property p_hold;
    @(posedge CORE_CLK) disable iff (!rst_n)
      is_hold && $past(is_hold) && !rs.burst
      |-> RD_DQS_OE_H == 2'b11 && RD_DQS_T_H == 2'b00
          && RD_DQS_C_H == 2'b11 && DQ_OE && DQ_H == 2'b11;
  endproperty
  a_hold: assert property (p_hold)
    else $error("training hold levels wrong");

  property p_post;
    @(posedge CORE_CLK) disable iff (!rst_n)
      $fell(rs.burst) && !rs.pre && !is_hold && !$past(is_hold)
      |-> RD_DQS_OE_H == 2'b10 && RD_DQS_T_H == 2'b00
          ##1 RD_DQS_OE_H != 2'b10;
  endproperty
  a_post: assert property (p_post)
    else $error("read postamble not half a clock");

  property p_bg;
    @(posedge CORE_CLK) disable iff (!rst_n)
      CMD_VALID && CMD_TYPE == CMD_ACT
      |=> ACT_BANK == ($past(r.x16) ? {1'b0, $past(CMD_BG[0]),
          $past(CMD_BA)} : {$past(CMD_BG), $past(CMD_BA)});
  endproperty
  a_bg: assert property (p_bg)
    else $error("bank group decode wrong");

endmodule // ddr_preamble_ctl

/* File: design/strobe_if.sv */
// Signals between the scheduler and one strobe sequencer
`timescale 1ns/1ps
interface strobe_if;
  logic [3:0] occ;     // Burst occupancy, bit 0 this clock
  logic       two_clk; // Two-clock preamble selected
  logic       hold;    // Training hold level
  logic [7:0] pat;     // Burst data pattern
  logic [1:0] t_h;     // True strobe, bit 1 first half
  logic [1:0] oe_h;    // Strobe drive enable per half
  logic [1:0] dq_h;    // Data level per half
  logic       dq_oe;   // Data drive enable
  logic       burst;   // Strobe toggling this clock
  logic       pre;     // Preamble this clock

  modport ctl (output occ, two_clk, hold, pat,
               input t_h, oe_h, dq_h, dq_oe, burst, pre);
  modport seq (input occ, two_clk, hold, pat,
               output t_h, oe_h, dq_h, dq_oe, burst, pre);
endinterface

/* File: design/strobe_seq.sv */
// Strobe and data shaper: preamble, burst toggling, half-clock postamble
`timescale 1ns/1ps
module strobe_seq
  import ddr_pre_pkg::*;
(
  input wire logic clk,   // Core clock
  input wire logic rst_n, // Synchronised reset, active low
  strobe_if.seq    sif    // Scheduler side
);

  typedef struct packed {
    logic [1:0] t_h;
    logic [1:0] oe_h;
    logic [1:0] dq_h;
    logic       dq_oe;
    logic       burst;
    logic       pre;
    logic [1:0] beat;
  } seq_s;

  seq_s r;
  seq_s n;
  logic [1:0] b;

  // Shape next clock from occupancy around it
  always_comb
  begin
    n = '0;
    b = sif.occ[0] ? r.beat + 2'd1 : 2'd0;
    if (sif.occ[1])
    begin
      n.burst = 1'b1;
      n.oe_h  = 2'b11;
      n.t_h   = 2'b10;
      n.dq_oe = 1'b1;
      n.beat  = b;
      n.dq_h  = {sif.pat[{b, 1'b0}], sif.pat[{b, 1'b1}]};
    end
    else if (sif.occ[2] || (sif.two_clk && sif.occ[3]))
    begin
      n.pre   = 1'b1;
      n.oe_h  = 2'b11;
      n.dq_oe = sif.hold;
      n.dq_h  = 2'b11;
    end
    else if (sif.occ[0])
    begin
      n.oe_h  = sif.hold ? 2'b11 : 2'b10;
      n.dq_oe = sif.hold;
      n.dq_h  = 2'b11;
    end
    else if (sif.hold)
    begin
      n.oe_h  = 2'b11;
      n.dq_oe = 1'b1;
      n.dq_h  = 2'b11;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= n;
  end

  // Outputs straight from flops
  assign sif.t_h   = r.t_h;
  assign sif.oe_h  = r.oe_h;
  assign sif.dq_h  = r.dq_h;
  assign sif.dq_oe = r.dq_oe;
  assign sif.burst = r.burst;
  assign sif.pre   = r.pre;

endmodule // strobe_seq

/* File: sim/ddr_host_model.sv */
// Behavioural memory controller that drives the command pins
`timescale 1ns/1ps
module ddr_host_model
  import ddr_pre_pkg::*;
#(
  parameter int RATE_MT = 2400, // Link data rate
  parameter int CCD_L   = 4,    // Same-group column gap, clocks
  parameter int RRD_L   = 4     // Same-group activate gap, clocks
)
(
  input  wire logic        clk,    // Core clock
  input  wire logic        crc_on, // Write CRC enabled
  output logic             valid,  // Command strobe
  output logic      [1:0]  typ,    // Command code
  output logic      [1:0]  bg,     // Bank group
  output logic      [1:0]  ba,     // Bank
  output logic      [2:0]  mr,     // Mode register select
  output logic      [12:0] op,     // Operand
  output logic             bc4     // Burst chop
);
  int         t_col = -9999, t_act = -9999, t_wr = -9999, cwl = 12;
  logic [1:0] g_col = 2'h0, g_act = 2'h0, g_wr = 2'h0;
  logic       rd2 = 1'b0, wr2 = 1'b0;

  // Pins idle at time zero
  initial {valid, typ, bg, ba, op, bc4} = '0;
  initial mr = MR_SEL_MR4;

  // Edge index of the current time
  function automatic int now();
    return int'($time / 64'd40);
  endfunction

  // Larger of a clock count and a time in picoseconds
  function automatic int ck(int n, int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c > n) ? c : n;
  endfunction

  // Primary write latency of the 2400 bin, two more for 2-clock preamble
  function automatic int cwl_pick(bit two);
    return two ? 14 : 12;
  endfunction

  // Issue a command no sooner than spacing allows; gap > 0 overrides
  task automatic issue(logic [1:0] c, logic [1:0] g, logic [1:0] b,
                       logic [12:0] o, logic k, int gap);
    int due;
    int need;
    due = 0;
    if (c == CMD_MRS && RATE_MT < 2400) o[12:11] = 2'b00;
    if (c == CMD_RD || c == CMD_WR)
    begin
      need = (g == g_col) ? ck(CCD_L, 6250) : 4;
      if ((rd2 && need == 5) || (wr2 && need == (crc_on ? 6 : 5)))
        need++;
      due = t_col + need;
      need = t_wr + cwl + 4 + ((g == g_wr) ? ck(4, 7500) : ck(2, 2500));
      if (c == CMD_RD && need > due) due = need;
    end
    if (c == CMD_ACT)
      due = t_act + ((g == g_act) ? ck(RRD_L, 6000) : 4);
    if (gap > 0) due = t_col + gap;
    @(posedge clk);
    while (now() + 1 < due) @(posedge clk);
    valid <= 1'b1;
    {typ, bg, ba, op, bc4} <= {c, g, b, o, k};
    @(posedge clk);
    valid <= 1'b0;
    if (c == CMD_RD || c == CMD_WR) {t_col, g_col} = {now(), g};
    if (c == CMD_WR) {t_wr, g_wr} = {now(), g};
    if (c == CMD_ACT) {t_act, g_act} = {now(), g};
    if (c == CMD_MRS) {wr2, rd2, cwl} = {o[12], o[11], cwl_pick(o[12])};
  endtask
endmodule // ddr_host_model

/* File: sim/test_ddr_preamble_ctl.sv */
// Self-checking bench for preamble modes, training and bank tracking
`timescale 1ns/1ps
module test_ddr_preamble_ctl
  import ddr_pre_pkg::*;
;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, crc = 1'b0;
  logic [3:0]  adr = 4'h0, be = 4'h0, actb, colb;
  logic [31:0] wd = '0, q, rdata;
  logic        wq, cv, cb, dqoe;
  logic [1:0]  cty, cbg, cba, dt, dc, doe, dq, wx, wn;
  logic [2:0]  cmr;
  logic [12:0] cop;
  int          fails = 0, comparisons = 0;

  // 25 MHz core clock
  always #20 clk = ~clk;

  ddr_preamble_ctl ddr_preamble_ctl_i (
    .CORE_CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
    .AVS_READDATA(q), .AVS_WAITREQUEST(wq), .CMD_VALID(cv),
    .CMD_TYPE(cty), .CMD_BG(cbg), .CMD_BA(cba), .CMD_MR(cmr),
    .CMD_OP(cop), .CMD_BC4(cb), .RD_DQS_T_H(dt), .RD_DQS_C_H(dc),
    .RD_DQS_OE_H(doe), .DQ_H(dq), .DQ_OE(dqoe), .WR_DQS_EXP_H(wx),
    .WR_DQS_EN_H(wn), .ACT_BANK(actb), .COL_BANK(colb));

  ddr_host_model ddr_host_model_i (
    .clk(clk), .crc_on(crc), .valid(cv), .typ(cty), .bg(cbg), .ba(cba),
    .mr(cmr), .op(cop), .bc4(cb));

  // Compare and count
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // One register access, held until waitrequest is sampled low
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] b);
    @(posedge clk);
    {rd, wr, adr, wd, be} <= {~w, w, a, d, b};
    do @(posedge clk); while (wq !== 1'b0);
    rdata = q;
    {rd, wr} <= 2'b00;
  endtask

  // One column command and its strobe shape, cycle by cycle
  task automatic trace(bit w, bit k, bit two, int lat);
    logic [1:0] eo, et;
    int i;
    ddr_host_model_i.issue(w ? CMD_WR : CMD_RD, 2'h1, 2'h2, '0, k, 0);
    for (int n = 1; n <= lat + 6; n++)
    begin
      @(posedge clk);
      #1;
      i = n - lat;
      {eo, et} = 4'b0000;
      if (i >= 0 && i < (k ? 2 : 4)) {eo, et} = 4'b1110;
      else if (i < 0 && i >= (two ? -2 : -1)) eo = 2'b11;
      else if (i == (k ? 2 : 4)) eo = 2'b10;
      chk("strobe enable", eo, w ? wn : doe);
      chk("strobe level", et, w ? wx : dt);
      if (!w) chk("strobe complement", 2'(~et), dc);
    end
  endtask

  // Register reset values and an unmapped offset
  task automatic t_reset();
    bus(0, REG_LAT, '0, '0);
    chk("latency reset", 32'h0000_0C0B, rdata);
    bus(0, REG_STAT, '0, '0);
    chk("status reset", 32'h0000_0000, rdata);
    bus(1, 4'h2, 32'hFFFF_FFFF, 4'hF);
    bus(0, 4'h2, '0, '0);
    chk("unmapped read", 32'h0000_0000, rdata);
    $display("test reset done");
  endtask

  // Every preamble combination with both burst lengths
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      ddr_host_model_i.issue(CMD_MRS, 0, 0, {m[1], m[0], 11'h0}, 0, 0);
      bus(0, REG_STAT, '0, '0);
      chk("preamble modes", {m[0], m[1]}, rdata[1:0]);
      bus(1, REG_LAT, {19'h0, 5'(ddr_host_model_i.cwl_pick(m[1])),
                       3'h0, 5'h05}, 4'hF);
      for (int k = 0; k < 2; k++)
      begin
        trace(0, k[0], m[0], 5);
        trace(1, k[0], m[1], ddr_host_model_i.cwl_pick(m[1]));
      end
    end
    $display("test modes done");
  endtask

  // Read preamble training entry, hold, page rules and exit
  task automatic t_train();
    logic [7:0] pb = 8'hB4;
    bus(1, REG_PAT, 32'hFFFF_B4FF, 4'h2);
    bus(0, REG_PAT, '0, '0);
    chk("pattern reg", 32'h0000_B400, rdata);
    ddr_host_model_i.issue(CMD_MRS, 0, 0, 13'h0400, 0, 0);
    bus(0, REG_STAT, '0, '0);
    chk("training refused", 2'b00, rdata[3:2]);
    bus(1, REG_CTRL, 32'h0000_0004, 4'hF);
    ddr_host_model_i.issue(CMD_MRS, 0, 0, 13'h0400, 0, 0);
    ddr_host_model_i.issue(CMD_RD, 0, 0, '0, 0, 0);
    repeat (9)
    begin
      @(posedge clk);
      #1;
      chk("quiet data", 3'b111, {dqoe, dq});
    end
    repeat (4) @(posedge clk);
    #1;
    chk("hold strobe", 6'b110011, {doe, dt, dc});
    ddr_host_model_i.issue(CMD_RD, 0, 0, 13'h0001, 0, 0);
    repeat (4) @(posedge clk);
    for (int j = 0; j < 4; j++)
    begin
      @(posedge clk);
      #1;
      chk("training burst", 2'b10, dt);
      chk("training data", {pb[2 * j], pb[2 * j + 1]}, dq);
    end
    repeat (2) @(posedge clk);
    #1;
    chk("back to hold", 4'b1100, {doe, dt});
    bus(1, REG_CTRL, 32'h0000_000C, 4'hF);
    bus(0, REG_CTRL, '0, '0);
    chk("control reg", 32'h0000_000C, rdata);
    ddr_host_model_i.issue(CMD_RD, 0, 0, '0, 0, 0);
    repeat (5) @(posedge clk);
    #1;
    chk("other page read", 2'b00, dt);
    ddr_host_model_i.issue(CMD_MRS, 0, 0, 13'h0000, 0, 0);
    bus(0, REG_STAT, '0, '0);
    chk("training off", 2'b00, rdata[3:2]);
    bus(1, REG_CTRL, 32'h0000_0000, 4'hF);
    $display("test training done");
  endtask

  // Bank group and bank decode for both organisations
  task automatic t_bank();
    ddr_host_model_i.issue(CMD_ACT, 2'h3, 2'h2, '0, 0, 0);
    bus(0, REG_STAT, '0, '0);
    chk("activate bank", 4'hE, rdata[11:8]);
    chk("activate port", 4'hE, actb);
    bus(1, REG_CTRL, 32'h0000_0001, 4'hF);
    ddr_host_model_i.issue(CMD_ACT, 2'h3, 2'h1, '0, 0, 0);
    ddr_host_model_i.issue(CMD_RD, 2'h3, 2'h3, '0, 0, 0);
    bus(0, REG_STAT, '0, '0);
    chk("narrow activate", 4'h5, rdata[11:8]);
    chk("narrow column", 4'h7, colb);
    bus(1, REG_CTRL, 32'h0000_0000, 4'hF);
    $display("test bank done");
  endtask

  // Forbidden column gaps under 2-clock preambles, with and without CRC
  task automatic t_gap();
    ddr_host_model_i.issue(CMD_MRS, 0, 0, 13'h0800, 0, 0);
    ddr_host_model_i.issue(CMD_RD, 0, 0, '0, 0, 0);
    ddr_host_model_i.issue(CMD_RD, 0, 0, '0, 0, 5);
    bus(0, REG_STAT, '0, '0);
    chk("read gap flag", 1'b1, rdata[STAT_VIOL]);
    bus(1, REG_STAT, 32'h0000_0010, 4'h1);
    bus(0, REG_STAT, '0, '0);
    chk("flag cleared", 1'b0, rdata[STAT_VIOL]);
    bus(1, REG_CTRL, 32'h0000_0002, 4'hF);
    crc <= 1'b1;
    ddr_host_model_i.issue(CMD_MRS, 0, 0, 13'h1000, 0, 0);
    ddr_host_model_i.issue(CMD_WR, 0, 0, '0, 0, 0);
    ddr_host_model_i.issue(CMD_WR, 0, 0, '0, 0, 5);
    bus(0, REG_STAT, '0, '0);
    chk("crc gap five", 1'b0, rdata[STAT_VIOL]);
    ddr_host_model_i.issue(CMD_WR, 0, 0, '0, 0, 6);
    bus(0, REG_STAT, '0, '0);
    chk("crc gap six", 1'b1, rdata[STAT_VIOL]);
    $display("test gap done");
  endtask

  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_modes();
    t_train();
    t_bank();
    t_gap();
    finish_test();
  end

  // Watchdog, ten thousand cycles
  initial
  begin
    #400_000;
    fails++;
    finish_test();
  end
endmodule // test_ddr_preamble_ctl
